// ---- zero_flag_clock_reset_pins.sv ----
// Zero flags, general-purpose outputs, clock output, reset sequencing and channel routing
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module zero_flag_clock_reset_pins #(
	parameter int WORD_W = 24,
	parameter int INIT_CYCLES = zero_flag_pkg::INIT_CYCLES,
	parameter int ZERO_SAMPLES = zero_flag_pkg::ZERO_SAMPLES
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_reset_n,
	input wire logic [zero_flag_pkg::ADDR_W-1:0] i_addr,
	input wire logic [zero_flag_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [zero_flag_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_word_valid,
	input wire logic [zero_flag_pkg::NUM_LINES-1:0][WORD_W-1:0] i_left_word,
	input wire logic [zero_flag_pkg::NUM_LINES-1:0][WORD_W-1:0] i_right_word,
	output logic [zero_flag_pkg::NUM_CHAN-1:0][WORD_W-1:0] o_chan_word,
	output logic o_chan1_zero_or_gp_out,
	output logic o_chan2_zero_or_gp_out,
	output logic o_chan3_zero_or_gp_out,
	output logic o_chan4_zero_or_gp_out,
	output logic o_chan5_zero_or_gp_out,
	output logic o_chan6_zero_or_gp_out,
	output logic o_chan7_zero_flag,
	output logic o_chan8_zero_flag,
	output logic o_all_channels_zero_flag,
	output logic o_buffered_clock_out,
	output logic o_in_reset,
	output logic o_irq
);
	localparam int NC = zero_flag_pkg::NUM_CHAN;
	localparam int NG = zero_flag_pkg::NUM_GP;
	localparam int ICW = $clog2(INIT_CYCLES + 1);
	localparam int ZCW = $clog2(ZERO_SAMPLES + 1);
	localparam logic [ICW-1:0] INIT_LAST = ICW'(INIT_CYCLES - 1);
	localparam logic [ZCW-1:0] ZERO_LAST = ZCW'(ZERO_SAMPLES - 1);
	localparam logic [ZCW-1:0] ZERO_FULL = ZCW'(ZERO_SAMPLES);

	typedef enum logic [1:0] {
		ST_INIT = 2'b01,
		ST_RUN = 2'b10
	} phase_e;
	// Register address match, shared by write and read decoding
	function automatic logic hit(input logic [zero_flag_pkg::ADDR_W-1:0] a,
			input logic [7:0] reg_addr);
		hit = (a == reg_addr);
	endfunction
	phase_e state_reg;
	logic [ICW-1:0] init_cnt_reg;
	logic clock_out_enable_reg, clock_out_halve_reg;
	logic [NG-1:0] gp_mode_reg, gp_value_reg;
	logic [NC-1:0][WORD_W-1:0] chan_reg, routed;
	logic [NC-1:0][ZCW-1:0] zero_cnt_reg;
	logic [NC-1:0] zero_flag_reg, zero_flag_next, pin_reg;
	logic all_zero_reg, all_zero_next, all_zero_pin_reg;
	logic [zero_flag_pkg::INT_W-1:0] int_status_reg, int_status_next, int_enable_reg;
	logic [zero_flag_pkg::INT_W-1:0] int_event, int_clear;
	logic [zero_flag_pkg::DATA_W-1:0] rdata_reg;
	logic irq_reg, in_reset_reg, run, reg_write, init_done_pulse;

	assign run = (state_reg == ST_RUN);
	// Registers accept writes only once initialization is over, except the interrupt clear, which acts at any time
	assign reg_write = i_wr && run;

	// Reset pin is active low: while low the sequence restarts at the first init cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_INIT;
			init_cnt_reg <= '0;
		end else if (!i_reset_n) begin
			state_reg <= ST_INIT;
			init_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_INIT: begin
					if (init_cnt_reg == INIT_LAST) begin
						state_reg <= ST_RUN;
						init_cnt_reg <= '0;
					end else begin
						init_cnt_reg <= init_cnt_reg + 1'b1;
					end
				end
				ST_RUN: state_reg <= ST_RUN;
				default: begin
					state_reg <= ST_INIT;
					init_cnt_reg <= '0;
				end
			endcase
		end
	end
	assign init_done_pulse = (state_reg == ST_INIT) && i_reset_n && (init_cnt_reg == INIT_LAST);

	// Control registers: defaults held during the whole initialization, then loaded
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			clock_out_enable_reg <= zero_flag_pkg::RST_CLOCK_OUT_ENABLE;
			clock_out_halve_reg <= zero_flag_pkg::RST_CLOCK_OUT_HALVE;
			gp_mode_reg <= zero_flag_pkg::RST_GP_MODE;
			gp_value_reg <= zero_flag_pkg::RST_GP_VALUE;
			int_enable_reg <= '0;
		end else if (!run) begin
			clock_out_enable_reg <= zero_flag_pkg::RST_CLOCK_OUT_ENABLE;
			clock_out_halve_reg <= zero_flag_pkg::RST_CLOCK_OUT_HALVE;
			gp_mode_reg <= zero_flag_pkg::RST_GP_MODE;
			gp_value_reg <= zero_flag_pkg::RST_GP_VALUE;
			int_enable_reg <= '0;
		end else if (reg_write) begin
			if (hit(i_addr, zero_flag_pkg::ADDR_CLOCK_CTRL)) begin
				clock_out_enable_reg <= i_wdata[zero_flag_pkg::BIT_CLOCK_OUT_ENABLE];
				clock_out_halve_reg <= i_wdata[zero_flag_pkg::BIT_CLOCK_OUT_HALVE];
			end
			if (hit(i_addr, zero_flag_pkg::ADDR_GP_MODE)) begin
				gp_mode_reg <= i_wdata[NG-1:0];
			end
			if (hit(i_addr, zero_flag_pkg::ADDR_GP_VALUE)) begin
				gp_value_reg <= i_wdata[NG-1:0];
			end
			if (hit(i_addr, zero_flag_pkg::ADDR_INT_ENABLE)) begin
				int_enable_reg <= i_wdata[zero_flag_pkg::INT_W-1:0];
			end
		end
	end

	// Route left words to odd outputs and right words to even outputs
	always_comb begin
		for (int n = 0; n < zero_flag_pkg::NUM_LINES; n++) begin
			routed[2*n] = i_left_word[n];
			routed[2*n+1] = i_right_word[n];
		end
	end

	// Channel output words, held at bipolar zero outside run
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			chan_reg <= '0;
		end else if (!run) begin
			chan_reg <= '0;
		end else if (i_word_valid) begin
			chan_reg <= routed;
		end
	end

	// Next zero flag: channel has carried zero words for the full count of samples
	always_comb begin
		for (int c = 0; c < NC; c++) begin
			zero_flag_next[c] = zero_flag_reg[c];
			if (i_word_valid) begin
				zero_flag_next[c] = (routed[c] == '0) && (zero_cnt_reg[c] >= ZERO_LAST);
			end
		end
		all_zero_next = &zero_flag_next;
	end

	// Zero detectors, one per channel
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			zero_cnt_reg <= '0;
			zero_flag_reg <= '0;
			all_zero_reg <= 1'b0;
		end else if (!run) begin
			zero_cnt_reg <= '0;
			zero_flag_reg <= '0;
			all_zero_reg <= 1'b0;
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (i_word_valid) begin
					if (routed[c] != '0) begin
						zero_cnt_reg[c] <= '0;
					end else if (zero_cnt_reg[c] != ZERO_FULL) begin
						zero_cnt_reg[c] <= zero_cnt_reg[c] + 1'b1;
					end
				end
			end
			zero_flag_reg <= zero_flag_next;
			all_zero_reg <= all_zero_next;
		end
	end

	// Flag pins: channels one to six may carry a software bit instead
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pin_reg <= '0;
			all_zero_pin_reg <= 1'b0;
		end else begin
			for (int c = 0; c < NC; c++) begin
				if (c < NG && gp_mode_reg[c]) begin
					pin_reg[c] <= gp_value_reg[c];
				end else begin
					pin_reg[c] <= zero_flag_reg[c];
				end
			end
			all_zero_pin_reg <= all_zero_reg;
		end
	end

	// Interrupt events and sticky status, set wins over clear
	always_comb begin
		int_event = '0;
		int_event[zero_flag_pkg::INT_ALL_ZERO_RISE] = all_zero_next && !all_zero_reg && run;
		int_event[zero_flag_pkg::INT_INIT_DONE] = init_done_pulse;
		int_event[zero_flag_pkg::INT_CHAN_ZERO_RISE] = |(zero_flag_next & ~zero_flag_reg) && run;
		int_clear = '0;
		if (i_wr && hit(i_addr, zero_flag_pkg::ADDR_INT_CLEAR)) begin
			int_clear = i_wdata[zero_flag_pkg::INT_W-1:0];
		end
		int_status_next = (int_status_reg & ~int_clear) | int_event;
	end
	// Sticky status and the registered interrupt line
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			int_status_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			int_status_reg <= int_status_next;
			irq_reg <= |(int_status_reg & int_enable_reg);
		end
	end

	// Read data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= '0;
			if (i_rd) begin
				if (hit(i_addr, zero_flag_pkg::ADDR_CLOCK_CTRL)) begin
					rdata_reg[zero_flag_pkg::BIT_CLOCK_OUT_ENABLE] <= clock_out_enable_reg;
					rdata_reg[zero_flag_pkg::BIT_CLOCK_OUT_HALVE] <= clock_out_halve_reg;
				end
				if (hit(i_addr, zero_flag_pkg::ADDR_GP_MODE)) begin
					rdata_reg[NG-1:0] <= gp_mode_reg;
				end
				if (hit(i_addr, zero_flag_pkg::ADDR_GP_VALUE)) begin
					rdata_reg[NG-1:0] <= gp_value_reg;
				end
				if (hit(i_addr, zero_flag_pkg::ADDR_FLAGS)) begin
					rdata_reg[NC-1:0] <= zero_flag_reg;
					rdata_reg[zero_flag_pkg::BIT_ALL_ZERO] <= all_zero_reg;
					rdata_reg[zero_flag_pkg::BIT_INIT_DONE] <= run;
				end
				if (hit(i_addr, zero_flag_pkg::ADDR_INT_STATUS)) begin
					rdata_reg[zero_flag_pkg::INT_W-1:0] <= int_status_reg;
				end
				if (hit(i_addr, zero_flag_pkg::ADDR_INT_ENABLE)) begin
					rdata_reg[zero_flag_pkg::INT_W-1:0] <= int_enable_reg;
				end
			end
		end
	end

	// Reset indication
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			in_reset_reg <= 1'b1;
		end else begin
			in_reset_reg <= !(run || init_done_pulse) || !i_reset_n;
		end
	end

	// Clock output divider
	clock_out_divider u_clock_out (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_enable(clock_out_enable_reg),
		.i_halve(clock_out_halve_reg),
		.o_clk_out(o_buffered_clock_out)
	);

	assign o_rdata = rdata_reg;
	assign o_chan_word = chan_reg;
	assign {o_chan8_zero_flag, o_chan7_zero_flag, o_chan6_zero_or_gp_out,
		o_chan5_zero_or_gp_out, o_chan4_zero_or_gp_out, o_chan3_zero_or_gp_out,
		o_chan2_zero_or_gp_out, o_chan1_zero_or_gp_out} = pin_reg;
	assign o_all_channels_zero_flag = all_zero_pin_reg;
	assign o_in_reset = in_reset_reg;
	assign o_irq = irq_reg;
	// Checks, all on the system clock and idle while the block reset is high
	default clocking cb_chk @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	property p_all_zero_and;
		all_zero_pin_reg |-> $past(&zero_flag_reg);
	endproperty
	a_all_zero_and: assert property (p_all_zero_and) else $error("all-zero not AND");
	property p_flag_pin;
		!$past(gp_mode_reg[0]) |-> (pin_reg[0] == $past(zero_flag_reg[0]));
	endproperty
	a_flag_pin: assert property (p_flag_pin) else $error("flag pin not from detector");
	property p_reset_pin;
		!i_reset_n |=> (state_reg == ST_INIT) && (init_cnt_reg == '0);
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin low not obeyed");
	property p_clock_off;
		!clock_out_enable_reg [*2] |-> !o_buffered_clock_out;
	endproperty
	a_clock_off: assert property (p_clock_off) else $error("clock out not held low");
	property p_clock_full;
		(clock_out_enable_reg && !clock_out_halve_reg) [*3]
			|-> (o_buffered_clock_out != $past(o_buffered_clock_out));
	endproperty
	a_clock_full: assert property (p_clock_full) else $error("full rate not toggling");
	property p_route;
		(run && i_word_valid) |=> (chan_reg[2] == $past(i_left_word[1]))
			&& (chan_reg[3] == $past(i_right_word[1]));
	endproperty
	a_route: assert property (p_route) else $error("line two routed wrongly");
	property p_init_len;
		($rose(run)) |-> $past(init_cnt_reg) == INIT_LAST;
	endproperty
	a_init_len: assert property (p_init_len) else $error("init length wrong");
	property p_mute;
		!run |=> (chan_reg == '0);
	endproperty
	a_mute: assert property (p_mute) else $error("output not muted in reset");
	property p_gp_pin;
		$past(gp_mode_reg[5]) |-> (pin_reg[5] == $past(gp_value_reg[5]));
	endproperty
	a_gp_pin: assert property (p_gp_pin) else $error("general output not from bit");
endmodule

`default_nettype wire

// ---- zero_flag_support.sv ----
// Shared constants and the buffered clock output divider
`timescale 1ns/1ps
`default_nettype none

package zero_flag_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register byte addresses
	localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h00;
	localparam logic [7:0] ADDR_GP_MODE = 8'h04;
	localparam logic [7:0] ADDR_GP_VALUE = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_INT_CLEAR = 8'h14;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h18;
	// Clock control fields
	localparam int BIT_CLOCK_OUT_ENABLE = 0;
	localparam int BIT_CLOCK_OUT_HALVE = 1;
	localparam logic RST_CLOCK_OUT_ENABLE = 1'b1;
	localparam logic RST_CLOCK_OUT_HALVE = 1'b0;
	// Flag readback fields
	localparam int BIT_ALL_ZERO = 8;
	localparam int BIT_INIT_DONE = 9;
	// Interrupt fields
	localparam int INT_W = 3;
	localparam int INT_ALL_ZERO_RISE = 0;
	localparam int INT_INIT_DONE = 1;
	localparam int INT_CHAN_ZERO_RISE = 2;
	// Channel counts and defaults
	localparam int NUM_LINES = 4;
	localparam int NUM_CHAN = 8;
	localparam int NUM_GP = 6;
	localparam logic [5:0] RST_GP_MODE = 6'h00;
	localparam logic [5:0] RST_GP_VALUE = 6'h00;
	localparam int INIT_CYCLES = 1024;
	localparam int ZERO_SAMPLES = 1024;
	// Divider phases of the clock output
	localparam logic [1:0] DIV_FULL_LAST = 2'h0;
	localparam logic [1:0] DIV_HALF_LAST = 2'h1;
endpackage

// Buffered clock output: toggles each cycle at full rate, every second cycle at half rate
module clock_out_divider (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_enable,
	input wire logic i_halve,
	output logic o_clk_out
);
	logic [1:0] phase_reg;
	logic clk_out_reg;

	// Phase counter and output toggle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			phase_reg <= 2'h0;
			clk_out_reg <= 1'b0;
		end else if (!i_enable) begin
			phase_reg <= 2'h0;
			clk_out_reg <= 1'b0;
		end else begin
			if (phase_reg >= (i_halve ? zero_flag_pkg::DIV_HALF_LAST
					: zero_flag_pkg::DIV_FULL_LAST)) begin
				phase_reg <= 2'h0;
				clk_out_reg <= ~clk_out_reg;
			end else begin
				phase_reg <= phase_reg + 2'h1;
			end
		end
	end
	assign o_clk_out = clk_out_reg;
endmodule

`default_nettype wire

// ---- audio_source_model.sv ----
// Far-side model: drives the reset pin and the per-line word pairs
`timescale 1ns/1ps
`default_nettype none

module audio_source_model #(
	parameter int W = 24
) (
	input wire logic i_clk,
	input wire logic i_send,
	input wire logic i_reset_req,
	input wire logic [3:0][W-1:0] i_left,
	input wire logic [3:0][W-1:0] i_right,
	output logic o_reset_n,
	output logic o_word_valid,
	output logic [3:0][W-1:0] o_left_word,
	output logic [3:0][W-1:0] o_right_word
);
	// Reset pin held low while asked, high for normal running
	always @(posedge i_clk) begin
		o_reset_n <= ~i_reset_req;
	end

	// One word pair per frame; between frames the lines keep changing
	always @(posedge i_clk) begin
		o_word_valid <= i_send;
		if (i_send) begin
			o_left_word <= i_left;
			o_right_word <= i_right;
		end else begin
			o_left_word <= ~o_left_word;
			o_right_word <= ~o_right_word;
		end
	end

	// Lines start at a known value
	initial begin
		o_reset_n = 1'b1;
		o_word_valid = 1'b0;
		o_left_word = '0;
		o_right_word = '0;
	end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the zero flag, clock output and reset pin block
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int W = 24;
	localparam int INIT_N = 8;
	localparam int ZERO_N = 2;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic send = 1'b0;
	logic reset_req = 1'b0;
	logic [3:0][W-1:0] lv = '0;
	logic [3:0][W-1:0] rv = '0;
	wire logic reset_n, word_valid;
	wire logic [3:0][W-1:0] lw, rw;
	logic [31:0] o_rdata;
	logic [7:0][W-1:0] o_chan_word;
	wire logic [7:0] pins;
	logic all_z, clk_out, in_reset, irq;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;

	// System clock, 50 ns period; words are sent only when a test asks, at no fixed rate
	always #25 i_clk = ~i_clk;

	audio_source_model #(.W(W)) i_src (.i_clk(i_clk), .i_send(send), .i_reset_req(reset_req),
		.i_left(lv), .i_right(rv), .o_reset_n(reset_n), .o_word_valid(word_valid),
		.o_left_word(lw), .o_right_word(rw));

	zero_flag_clock_reset_pins #(.WORD_W(W), .INIT_CYCLES(INIT_N), .ZERO_SAMPLES(ZERO_N)) i_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_reset_n(reset_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_word_valid(word_valid), .i_left_word(lw), .i_right_word(rw),
		.o_chan_word(o_chan_word), .o_chan1_zero_or_gp_out(pins[0]),
		.o_chan2_zero_or_gp_out(pins[1]), .o_chan3_zero_or_gp_out(pins[2]),
		.o_chan4_zero_or_gp_out(pins[3]), .o_chan5_zero_or_gp_out(pins[4]),
		.o_chan6_zero_or_gp_out(pins[5]), .o_chan7_zero_flag(pins[6]),
		.o_chan8_zero_flag(pins[7]), .o_all_channels_zero_flag(all_z),
		.o_buffered_clock_out(clk_out), .o_in_reset(in_reset), .o_irq(irq));

	// Verdict and end of run
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge i_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_count = err_count + 1;
			final_report();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count = check_count + 1;
		if (got !== exp) begin
			err_count = err_count + 1;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	task automatic send_words(input logic [3:0][W-1:0] l, input logic [3:0][W-1:0] r);
		@(posedge i_clk);
		send <= 1'b1;
		lv <= l;
		rv <= r;
		@(posedge i_clk);
		send <= 1'b0;
		tick(3);
	endtask

	task automatic wait_run(output int n);
		n = 0;
		while (in_reset === 1'b1 && n < 200) begin
			tick(1);
			n = n + 1;
		end
	endtask

	task automatic t_init();
		int n;
		logic [31:0] d;
		check(32'(in_reset), 32'h1, "in reset");
		check(32'(o_chan_word[0]), 32'h0, "muted");
		@(posedge i_clk);
		i_rst <= 1'b0;
		wait_run(n);
		check(32'(n >= INIT_N && n <= INIT_N + 2), 32'h1, "init length");
		reg_read(zero_flag_pkg::ADDR_CLOCK_CTRL, d);
		check(d, 32'h1, "clock ctrl default");
		reg_read(zero_flag_pkg::ADDR_GP_MODE, d);
		check(d, 32'h0, "gp mode default");
		reg_read(8'h1C, d);
		check(d, 32'h0, "unmapped read");
		reg_read(zero_flag_pkg::ADDR_INT_STATUS, d);
		check(d[1], 1'b1, "init status");
		check(32'(irq), 32'h0, "irq masked");
		reg_write(zero_flag_pkg::ADDR_INT_ENABLE, 32'h2);
		tick(2);
		check(32'(irq), 32'h1, "irq raised");
		reg_write(zero_flag_pkg::ADDR_INT_CLEAR, 32'h2);
		tick(2);
		check(32'(irq), 32'h0, "irq cleared");
		$display("test init done");
	endtask

	task automatic t_route();
		logic [3:0][W-1:0] l, r;
		for (int n = 0; n < 4; n++) begin
			l[n] = 24'hA00001 + 24'(n);
			r[n] = 24'hB00010 + 24'(n);
		end
		send_words(l, r);
		for (int n = 0; n < 4; n++) begin
			check(32'(o_chan_word[2*n]), 32'(l[n]), "left route");
			check(32'(o_chan_word[2*n+1]), 32'(r[n]), "right route");
		end
		check(32'({all_z, pins}), 32'h0, "flags clear");
		$display("test route done");
	endtask

	task automatic t_zero();
		logic [31:0] d;
		logic [3:0][W-1:0] z, r;
		z = '0;
		r = '0;
		r[3] = 24'h000001;
		repeat (ZERO_N) send_words(z, r);
		check(32'(pins), 32'h7F, "seven flags");
		check(32'(all_z), 32'h0, "and of flags");
		repeat (ZERO_N) send_words(z, z);
		check(32'(pins), 32'hFF, "eight flags");
		check(32'(all_z), 32'h1, "all zero");
		reg_read(zero_flag_pkg::ADDR_INT_STATUS, d);
		check(d & 32'h5, 32'h5, "zero events");
		reg_read(zero_flag_pkg::ADDR_FLAGS, d);
		check(d, 32'h3FF, "flags register");
		r = '0;
		r[0] = 24'h800000;
		send_words(z, r);
		check(32'(pins), 32'hFD, "chan2 cleared");
		check(32'(all_z), 32'h0, "all zero falls");
		$display("test zero done");
	endtask

	task automatic t_gp();
		logic [3:0][W-1:0] l;
		l = {4{24'h000100}};
		send_words(l, l);
		reg_write(zero_flag_pkg::ADDR_GP_MODE, 32'h3F);
		reg_write(zero_flag_pkg::ADDR_GP_VALUE, 32'h15);
		tick(2);
		check(32'(pins), 32'h15, "gp outputs");
		reg_write(zero_flag_pkg::ADDR_GP_MODE, 32'h0);
		tick(2);
		check(32'(pins), 32'h0, "zero mode back");
		$display("test gp done");
	endtask

	task automatic toggles(input logic [31:0] ctrl, input int exp, input string msg);
		int n;
		logic prev;
		reg_write(zero_flag_pkg::ADDR_CLOCK_CTRL, ctrl);
		tick(4);
		prev = clk_out;
		n = 0;
		repeat (16) begin
			tick(1);
			n = n + 32'(clk_out !== prev);
			prev = clk_out;
		end
		check(32'(n), 32'(exp), msg);
	endtask

	task automatic t_clk();
		toggles(32'h1, 16, "full rate");
		toggles(32'h3, 8, "half rate");
		toggles(32'h0, 0, "disabled");
		check(32'(clk_out), 32'h0, "disabled low");
		$display("test clock done");
	endtask

	task automatic t_pin_reset();
		int n;
		logic [31:0] d;
		logic [3:0][W-1:0] l;
		l = {4{24'h123456}};
		reg_write(zero_flag_pkg::ADDR_CLOCK_CTRL, 32'h3);
		send_words(l, l);
		@(posedge i_clk);
		reset_req <= 1'b1;
		tick(3);
		check(32'(in_reset), 32'h1, "pin reset");
		check(32'(o_chan_word[0]), 32'h0, "muted by pin");
		send_words(l, l);
		check(32'(o_chan_word[7]), 32'h0, "still muted");
		@(posedge i_clk);
		reset_req <= 1'b0;
		tick(1);
		wait_run(n);
		check(32'(n >= INIT_N && n <= INIT_N + 3), 32'h1, "reinit length");
		reg_read(zero_flag_pkg::ADDR_CLOCK_CTRL, d);
		check(d, 32'h1, "defaults reloaded");
		$display("test pin reset done");
	endtask

	// Main sequence
	initial begin
		@(posedge i_clk);
		#1;
		t_init();
		t_route();
		t_zero();
		t_gp();
		t_clk();
		t_pin_reset();
		final_report();
	end
endmodule
`default_nettype wire
